// File: cpurs_core.sv
// CPU core register set with internal RAM, stack and flags
`timescale 1ns/1ns
`default_nettype none
module cpurs_core (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    // Operation port from the sequencer
    input  wire logic                op_valid,
    input  wire cpurs_pkg::cpurs_op_e op_code,
    input  wire logic [7:0]          op_addr,
    input  wire logic [7:0]          op_wdata,
    input  wire logic [15:0]         op_target,
    output logic                     op_ready,
    // Read answer
    output logic                     rd_valid,
    output logic [7:0]               rd_data,
    // Program space
    output logic [23:0]              prog_addr,
    input  wire logic                prog_mode,
    // External data space
    output logic [23:0]              xd_addr,
    output logic [7:0]               xd_wdata,
    output logic                     xd_rd,
    output logic                     xd_wr,
    output logic                     xd_display_sel,
    input  wire logic                xd_flash_sel,
    input  wire logic [7:0]          xd_rdata,
    // Architectural state view
    output logic [7:0]               acc_q,
    output logic [7:0]               b_q,
    output logic [7:0]               sp_q,
    output logic [7:0]               flags_q,
    output logic [15:0]              pc_q,
    output logic [15:0]              external_data_pointer_q,
    output logic [7:0]               page_q
);
    import cpurs_pkg::*;

    typedef struct packed {
        cpurs_state_e state;
        logic [7:0]   sp;
        logic [15:0]  pc;
        logic [7:0]   acc;
        logic [7:0]   b;
        logic [7:0]   flg;
        logic [7:0]   external_pointer_high;
        logic [7:0]   external_pointer_low;
        logic [7:0]   page;
        logic [15:0]  tgt;
        logic [7:0]   baddr;
        logic [2:0]   bidx;
        logic         bval;
        logic         rv;
        cpurs_rsrc_e  rsrc;
        logic [7:0]   hold;
        logic         xrd;
        logic         xwr;
        logic [7:0]   xwd;
    } cpurs_st_s;

    cpurs_st_s  st_r;
    cpurs_st_s  st_nxt;
    logic       ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_q;
    logic       parity;

    cpurs_ram u_ram (
        .clk_sys (clk_sys),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (ram_wdata),
        .q       (ram_q)
    );

    assign parity = ~(^st_r.acc);

    always_comb begin
        logic [8:0]  sum9;
        logic [4:0]  half5;
        logic [15:0] prod;
        logic        cin;
        logic [7:0]  res;
        logic [7:0]  mask;
        sum9   = 9'h000;
        half5  = 5'h00;
        prod   = 16'h0000;
        cin    = 1'b0;
        res    = 8'h00;
        mask   = 8'h00;
        st_nxt = st_r;
        st_nxt.rv  = 1'b0;
        st_nxt.xrd = 1'b0;
        st_nxt.xwr = 1'b0;
        ram_we    = 1'b0;
        ram_addr  = 8'h00;
        ram_wdata = 8'h00;
        case (st_r.state)
            ST_IDLE: begin
                if (st_r.xrd) begin
                    // External read data is sampled in the cycle the strobe is high
                    st_nxt.hold = xd_rdata;
                    st_nxt.rsrc = RS_HOLD;
                    st_nxt.rv   = 1'b1;
                end else if (op_valid) begin
                    case (op_code)
                        OP_STEP: begin
                            st_nxt.pc = st_r.pc + 16'h0001;
                        end
                        OP_JUMP: begin
                            st_nxt.pc = op_target;
                        end
                        OP_DIR_RD: begin
                            // upper half direct goes to special space
                            st_nxt.rv = 1'b1;
                            if (op_addr >= SFR_BASE) begin
                                st_nxt.rsrc = RS_HOLD;
                                if (op_addr == ADR_SP) begin
                                    st_nxt.hold = st_r.sp;
                                end else if (op_addr == ADR_DPL) begin
                                    st_nxt.hold = st_r.external_pointer_low;
                                end else if (op_addr == ADR_DPH) begin
                                    st_nxt.hold = st_r.external_pointer_high;
                                end else if (op_addr == ADR_PAGE) begin
                                    st_nxt.hold = st_r.page;
                                end else if (op_addr == ADR_FLG) begin
                                    st_nxt.hold = {st_r.flg[7:1], parity};
                                end else if (op_addr == ADR_ACC) begin
                                    st_nxt.hold = st_r.acc;
                                end else if (op_addr == ADR_B) begin
                                    st_nxt.hold = st_r.b;
                                end else begin
                                    st_nxt.hold = 8'h00;
                                end
                            end else begin
                                st_nxt.rsrc = RS_RAM;
                                ram_addr    = op_addr;
                            end
                        end
                        OP_DIR_WR: begin
                            if (op_addr >= SFR_BASE) begin
                                if (op_addr == ADR_SP) begin
                                    st_nxt.sp = op_wdata;
                                end else if (op_addr == ADR_DPL) begin
                                    st_nxt.external_pointer_low = op_wdata;
                                end else if (op_addr == ADR_DPH) begin
                                    st_nxt.external_pointer_high = op_wdata;
                                end else if (op_addr == ADR_PAGE) begin
                                    st_nxt.page = op_wdata;
                                end else if (op_addr == ADR_FLG) begin
                                    // Parity bit is derived, write ignored
                                    st_nxt.flg = {op_wdata[7:1], 1'b0};
                                end else if (op_addr == ADR_ACC) begin
                                    st_nxt.acc = op_wdata;
                                end else if (op_addr == ADR_B) begin
                                    st_nxt.b = op_wdata;
                                end
                            end else begin
                                ram_we    = 1'b1;
                                ram_addr  = op_addr;
                                ram_wdata = op_wdata;
                            end
                        end
                        OP_IND_RD: begin
                            // indirect reaches all 256 RAM bytes
                            st_nxt.rv   = 1'b1;
                            st_nxt.rsrc = RS_RAM;
                            ram_addr    = op_addr;
                        end
                        OP_IND_WR: begin
                            ram_we    = 1'b1;
                            ram_addr  = op_addr;
                            ram_wdata = op_wdata;
                        end
                        OP_REG_RD, OP_REG_WR: begin
                            // banks lie in bytes 0 to 31
                            ram_addr = {3'b000, st_r.flg[FLG_RS1],
                                        st_r.flg[FLG_RS0], op_addr[2:0]};
                            if (op_code == OP_REG_WR) begin
                                ram_we    = 1'b1;
                                ram_wdata = op_wdata;
                            end else begin
                                st_nxt.rv   = 1'b1;
                                st_nxt.rsrc = RS_RAM;
                            end
                        end
                        OP_BIT_RD, OP_BIT_WR: begin
                            // bit n lives in byte 20h plus n/8
                            ram_addr     = BIT_BASE + {4'h0, op_addr[6:3]};
                            st_nxt.baddr = ram_addr;
                            st_nxt.bidx  = op_addr[2:0];
                            st_nxt.bval  = op_wdata[0];
                            if (op_addr >= SFR_BASE) begin
                                // Special-space bits are not held here
                                st_nxt.rv   = (op_code == OP_BIT_RD);
                                st_nxt.rsrc = RS_HOLD;
                                st_nxt.hold = 8'h00;
                            end else if (op_code == OP_BIT_RD) begin
                                st_nxt.rv   = 1'b1;
                                st_nxt.rsrc = RS_BIT;
                            end else begin
                                st_nxt.state = ST_BIT_WB;
                            end
                        end
                        OP_PUSH: begin
                            st_nxt.sp = st_r.sp + 8'h01;
                            ram_we    = 1'b1;
                            ram_addr  = st_r.sp + 8'h01;
                            ram_wdata = op_wdata;
                        end
                        OP_CALL, OP_INT: begin
                            st_nxt.sp    = st_r.sp + 8'h01;
                            ram_we       = 1'b1;
                            ram_addr     = st_r.sp + 8'h01;
                            ram_wdata    = st_r.pc[7:0];
                            st_nxt.state = ST_CALL_HI;
                            if (op_code == OP_INT) begin
                                st_nxt.tgt = VEC_BASE +
                                    (16'(op_addr[4:0]) << VEC_SHIFT);
                            end else begin
                                st_nxt.tgt = op_target;
                            end
                        end
                        OP_ADD, OP_ADDC: begin
                            cin   = (op_code == OP_ADDC) & st_r.flg[FLG_CY];
                            sum9  = {1'b0, st_r.acc} + {1'b0, op_wdata}
                                    + {8'h00, cin};
                            half5 = {1'b0, st_r.acc[3:0]}
                                    + {1'b0, op_wdata[3:0]} + {4'h0, cin};
                            st_nxt.acc = sum9[7:0];
                            st_nxt.flg[FLG_CY] = sum9[8];
                            st_nxt.flg[FLG_AC] = half5[4];
                            st_nxt.flg[FLG_OV] =
                                (st_r.acc[7] == op_wdata[7]) &&
                                (sum9[7] != st_r.acc[7]);
                        end
                        OP_SUBB: begin
                            // Carry means no borrow, so borrow-in is its inverse
                            cin   = ~st_r.flg[FLG_CY];
                            sum9  = {1'b0, st_r.acc} - {1'b0, op_wdata}
                                    - {8'h00, cin};
                            half5 = {1'b0, st_r.acc[3:0]}
                                    - {1'b0, op_wdata[3:0]} - {4'h0, cin};
                            st_nxt.acc = sum9[7:0];
                            st_nxt.flg[FLG_CY] = ~sum9[8];
                            st_nxt.flg[FLG_AC] = ~half5[4];
                            st_nxt.flg[FLG_OV] =
                                (st_r.acc[7] != op_wdata[7]) &&
                                (sum9[7] != st_r.acc[7]);
                        end
                        OP_RLC: begin
                            st_nxt.acc = {st_r.acc[6:0], st_r.flg[FLG_CY]};
                            st_nxt.flg[FLG_CY] = st_r.acc[7];
                        end
                        OP_RRC: begin
                            st_nxt.acc = {st_r.flg[FLG_CY], st_r.acc[7:1]};
                            st_nxt.flg[FLG_CY] = st_r.acc[0];
                        end
                        OP_MUL: begin
                            // product high half lands in multiplier
                            prod = 16'(st_r.acc) * 16'(st_r.b);
                            st_nxt.acc = prod[7:0];
                            st_nxt.b   = prod[15:8];
                            st_nxt.flg[FLG_CY] = 1'b0;
                            st_nxt.flg[FLG_OV] = (prod[15:8] != 8'h00);
                        end
                        OP_DIV: begin
                            // quotient in accumulator, rest in multiplier
                            st_nxt.flg[FLG_CY] = 1'b0;
                            if (st_r.b == 8'h00) begin
                                st_nxt.flg[FLG_OV] = 1'b1;
                            end else begin
                                st_nxt.acc = st_r.acc / st_r.b;
                                st_nxt.b   = st_r.acc % st_r.b;
                                st_nxt.flg[FLG_OV] = 1'b0;
                            end
                        end
                        OP_CLEAR_SIGNED_FLAG_INSTR: begin
                            st_nxt.flg[FLG_OV] = 1'b0;
                        end
                        OP_BITTEST: begin
                            st_nxt.flg[FLG_OV] = op_wdata[6];
                        end
                        OP_XRD: begin
                            st_nxt.xrd = 1'b1;
                        end
                        OP_XWR: begin
                            st_nxt.xwr = 1'b1;
                            st_nxt.xwd = op_wdata;
                        end
                        OP_PAGE: begin
                            st_nxt.page = op_wdata;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_CALL_HI: begin
                st_nxt.sp    = st_r.sp + 8'h01;
                ram_we       = 1'b1;
                ram_addr     = st_r.sp + 8'h01;
                ram_wdata    = st_r.pc[15:8];
                st_nxt.pc    = st_r.tgt;
                st_nxt.state = ST_IDLE;
            end
            ST_BIT_WB: begin
                mask      = 8'h01 << st_r.bidx;
                res       = st_r.bval ? (ram_q | mask) : (ram_q & ~mask);
                ram_we    = 1'b1;
                ram_addr  = st_r.baddr;
                ram_wdata = res;
                st_nxt.state = ST_IDLE;
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r       <= '0;
            st_r.state <= ST_IDLE;
            st_r.sp    <= SP_RST;
            st_r.pc    <= PC_RST;
            st_r.acc   <= ACC_RST;
            st_r.b     <= B_RST;
            st_r.flg   <= FLG_RST;
            st_r.external_pointer_high   <= DPX_RST;
            st_r.external_pointer_low   <= DPX_RST;
            st_r.page  <= PAGE_RST;
            st_r.rsrc  <= RS_HOLD;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Back-to-back ops stall only behind multi-cycle work
    assign op_ready = (st_r.state == ST_IDLE) && !st_r.xrd;

    assign rd_valid = st_r.rv;
    always_comb begin
        if (st_r.rsrc == RS_RAM) begin
            rd_data = ram_q;
        end else if (st_r.rsrc == RS_BIT) begin
            rd_data = {7'h00, ram_q[st_r.bidx]};
        end else begin
            rd_data = st_r.hold;
        end
    end

    // fetch address kept apart from data address
    assign prog_addr = {st_r.page, st_r.pc};
    assign xd_addr   = {st_r.page, st_r.external_pointer_high, st_r.external_pointer_low};
    assign xd_wdata  = st_r.xwd;
    assign xd_rd     = st_r.xrd;
    // flash writes pass only in programming mode
    assign xd_wr     = st_r.xwr && (!xd_flash_sel || prog_mode);
    // top window hits the display buffer, rest to backup RAM
    assign xd_display_sel = (st_r.external_pointer_high == XD_DISP_HI);

    assign acc_q   = st_r.acc;
    assign b_q     = st_r.b;
    assign sp_q    = st_r.sp;
    // fixed flag order, parity in bit 0
    assign flags_q = {st_r.flg[7:1], parity};
    assign pc_q    = st_r.pc;
    assign external_data_pointer_q  = {st_r.external_pointer_high, st_r.external_pointer_low};
    assign page_q  = st_r.page;

endmodule : cpurs_core
`default_nettype wire

// File: cpurs_pkg.sv
// Shared constants and types for the CPU core register set
package cpurs_pkg;

    // Reset values
    localparam logic [7:0]  SP_RST    = 8'h07;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  FLG_RST   = 8'h00;
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [7:0]  B_RST     = 8'h00;
    localparam logic [7:0]  DPX_RST   = 8'h00;
    localparam logic [7:0]  PAGE_RST  = 8'h00;

    // Interrupt vector slots: base plus source times eight
    localparam logic [15:0] VEC_BASE  = 16'h0003;
    localparam int          VEC_SHIFT = 3;

    // Internal RAM layout
    localparam logic [7:0]  SFR_BASE  = 8'h80;
    localparam logic [7:0]  BIT_BASE  = 8'h20;

    // Flags word field positions
    localparam int FLG_CY  = 7;
    localparam int FLG_AC  = 6;
    localparam int FLG_F0  = 5;
    localparam int FLG_RS1 = 4;
    localparam int FLG_RS0 = 3;
    localparam int FLG_OV  = 2;
    localparam int FLG_P   = 0;

    // Direct addresses in the special register space
    localparam logic [7:0]  ADR_SP    = 8'h81;
    localparam logic [7:0]  ADR_DPL   = 8'h82;
    localparam logic [7:0]  ADR_DPH   = 8'h83;
    localparam logic [7:0]  ADR_PAGE  = 8'h91;
    localparam logic [7:0]  ADR_FLG   = 8'hd0;
    localparam logic [7:0]  ADR_ACC   = 8'he0;
    localparam logic [7:0]  ADR_B     = 8'hf0;

    // High byte of the display-channel buffer window in data space
    localparam logic [7:0]  XD_DISP_HI = 8'hff;

    // Operations issued by the instruction sequencer
    typedef enum logic [4:0] {
        OP_NOP, OP_STEP, OP_JUMP, OP_DIR_RD, OP_DIR_WR, OP_IND_RD,
        OP_IND_WR, OP_REG_RD, OP_REG_WR, OP_BIT_RD, OP_BIT_WR, OP_PUSH,
        OP_CALL, OP_INT, OP_ADD, OP_ADDC, OP_SUBB, OP_RLC, OP_RRC,
        OP_MUL, OP_DIV, OP_CLEAR_SIGNED_FLAG_INSTR, OP_BITTEST, OP_XRD, OP_XWR, OP_PAGE
    } cpurs_op_e;

    typedef enum {ST_IDLE, ST_CALL_HI, ST_BIT_WB} cpurs_state_e;

    typedef enum logic [1:0] {RS_RAM, RS_BIT, RS_HOLD} cpurs_rsrc_e;

endpackage : cpurs_pkg

// File: cpurs_ram.sv
// Internal data RAM, 256 bytes, registered read
`timescale 1ns/1ns
`default_nettype none
module cpurs_ram (
    // Clock
    input  wire logic       clk_sys,
    // Access port
    input  wire logic       we,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);
    logic [7:0] mem [0:255];

    // Read-first: q shows the old byte on a write
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        q <= mem[addr];
    end
endmodule : cpurs_ram
`default_nettype wire

// File: cpurs_core_asserts.sv
// Concurrent checks on the CPU core register set ports
`timescale 1ns/1ns
`default_nettype none
module cpurs_core_asserts (
    // Watched ports
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire logic                 op_valid,
    input wire cpurs_pkg::cpurs_op_e op_code,
    input wire logic [7:0]           op_addr,
    input wire logic [7:0]           op_wdata,
    input wire logic [15:0]          op_target,
    input wire logic                 op_ready,
    input wire logic                 prog_mode,
    input wire logic                 xd_wr,
    input wire logic                 xd_flash_sel,
    input wire logic [7:0]           acc_q,
    input wire logic [7:0]           sp_q,
    input wire logic [7:0]           flags_q,
    input wire logic [15:0]          pc_q
);
    import cpurs_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic took;
    assign took = op_valid && op_ready;
    property p_sp_rst; $rose(rst_n) |-> sp_q == 8'h07; endproperty
    a_sp_rst: assert property (p_sp_rst) else $error("bad sp reset");
    property p_pc_rst; $rose(rst_n) |-> pc_q == 16'h0000; endproperty
    a_pc_rst: assert property (p_pc_rst) else $error("bad pc reset");
    property p_par; flags_q[0] == ~^acc_q; endproperty
    a_par: assert property (p_par) else $error("bad parity");
    property p_call; took && op_code == OP_CALL |=> !op_ready
        && sp_q == $past(sp_q) + 8'h01 ##1 sp_q == $past(sp_q, 2) + 8'h02
        && pc_q == $past(op_target, 2); endproperty
    a_call: assert property (p_call) else $error("bad call push");
    property p_int; took && op_code == OP_INT |=> ##1
        pc_q == {8'h00, $past(op_addr[4:0], 2), 3'b000} + 16'h0003;
    endproperty
    a_int: assert property (p_int) else $error("bad vector");
    property p_add; took && op_code == OP_ADD |=> {flags_q[7], acc_q}
        == {1'b0, $past(acc_q)} + {1'b0, $past(op_wdata)}; endproperty
    a_add: assert property (p_add) else $error("bad add carry");
    property p_clear_signed_flag_instr; took && op_code == OP_CLEAR_SIGNED_FLAG_INSTR |=> !flags_q[2]; endproperty
    a_clear_signed_flag_instr: assert property (p_clear_signed_flag_instr) else $error("bad clear");
    // Flash stays read-only outside programming
    property p_fl; xd_wr |-> !xd_flash_sel || prog_mode;
    endproperty
    a_fl: assert property (p_fl) else $error("bad flash write");
endmodule : cpurs_core_asserts
bind cpurs_core cpurs_core_asserts u_chk (.*);
`default_nettype wire

// File: cpu_core_register_set_test.sv
// Self-checking bench for the CPU core register set
`timescale 1ns/1ns
`default_nettype none
module cpu_core_register_set_test;
    import cpurs_pkg::*;
    logic        clk_sys = 1'b0, rst_n = 1'b0, op_valid = 1'b0;
    logic        prog_mode = 1'b0, xd_flash_sel = 1'b0;
    logic        op_ready, rd_valid, xd_rd, xd_wr, xd_display_sel;
    cpurs_op_e   op_code = OP_NOP;
    logic [7:0]  op_addr = 8'h00, op_wdata = 8'h00, xd_rdata = 8'h00;
    logic [7:0]  rd_data, xd_wdata, acc_q, b_q, sp_q, flags_q, page_q;
    logic [15:0] op_target = 16'h0000, pc_q, external_data_pointer_q;
    logic [23:0] prog_addr, xd_addr;
    int          error_cnt = 0, checked = 0;
    cpurs_core DUT (.*);
    always #50 clk_sys = ~clk_sys;
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : chk
    // Request held until taken; old request stays up while refused
    task automatic op(input cpurs_op_e c, input logic [7:0] a, d,
                      input logic [15:0] t = 16'h0000);
        for (int n = 0; op_ready !== 1'b1; n++) begin
            if (n > 20) begin
                error_cnt++;
                give_verdict();
            end
            @(negedge clk_sys);
        end
        op_code = c;
        op_addr = a;
        op_wdata = d;
        op_target = t;
        op_valid = 1'b1;
        @(negedge clk_sys);
    endtask : op
    task automatic t_stack();
        op(OP_JUMP, 8'h00, 8'h00, 16'h1234);
        op(OP_CALL, 8'h00, 8'h00, 16'h0400);
        op(OP_IND_RD, 8'h08, 8'h00);
        chk(8'h34, rd_data);
        op(OP_IND_RD, 8'h09, 8'h00);
        chk(8'h12, rd_data);
        chk(16'h0400, pc_q);
        op(OP_INT, 8'h02, 8'h00);
        op(OP_NOP, 8'h00, 8'h00);
        chk(16'h0013, pc_q);
        chk(8'h0b, sp_q);
    endtask : t_stack
    task automatic t_alu();
        op(OP_DIR_WR, ADR_ACC, 8'h8f);
        op(OP_ADD, 8'h00, 8'h91);
        chk(8'h20, acc_q);
        chk(8'hc4, flags_q & 8'hc5);
        op(OP_CLEAR_SIGNED_FLAG_INSTR, 8'h00, 8'h00);
        chk(8'h00, flags_q & 8'h04);
        op(OP_DIR_WR, ADR_B, 8'h03);
        op(OP_MUL, 8'h00, 8'h00);
        chk(16'h0060, {b_q, acc_q});
    endtask : t_alu
    task automatic t_bank();
        op(OP_DIR_WR, ADR_FLG, 8'h18);
        op(OP_REG_WR, 8'h02, 8'h5a);
        op(OP_IND_RD, 8'h1a, 8'h00);
        chk(8'h5a, rd_data);
        op(OP_IND_WR, 8'h21, 8'h00);
        op(OP_BIT_WR, 8'h08, 8'h01);
        op(OP_IND_RD, 8'h21, 8'h00);
        chk(8'h01, rd_data);
    endtask : t_bank
    task automatic t_xdata();
        op(OP_DIR_WR, ADR_DPH, 8'hff);
        op(OP_DIR_WR, ADR_DPL, 8'h10);
        chk(16'hff10, external_data_pointer_q);
        chk(1'b1, xd_display_sel);
        xd_rdata = 8'h3c;
        op(OP_XRD, 8'h00, 8'h00);
        chk(1'b1, xd_rd);
        @(negedge clk_sys);
        chk(8'h3c, rd_data);
        xd_flash_sel = 1'b1;
        op(OP_XWR, 8'h00, 8'h77);
        chk(1'b0, xd_wr);
        prog_mode = 1'b1;
        op(OP_XWR, 8'h00, 8'h77);
        chk(9'h177, {xd_wr, xd_wdata});
    endtask : t_xdata
    task automatic t_more();
        op(OP_PAGE, 8'h00, 8'h02);
        chk(24'h020013, prog_addr);
        chk(24'h02ff10, xd_addr);
        op(OP_DIR_RD, ADR_PAGE, 8'h00);
        chk(9'h102, {rd_valid, rd_data});
        op(OP_STEP, 8'h00, 8'h00);
        chk(24'h020014, prog_addr);
        op(OP_PUSH, 8'h00, 8'ha5);
        op(OP_DIR_RD, ADR_SP, 8'h00);
        chk(8'h0c, rd_data);
        op(OP_IND_RD, 8'h0c, 8'h00);
        chk(8'ha5, rd_data);
        op(OP_DIR_RD, 8'h1a, 8'h00);
        chk(8'h5a, rd_data);
        op(OP_BIT_RD, 8'h08, 8'h00);
        chk(8'h01, rd_data);
        op(OP_DIR_WR, ADR_ACC, 8'h10);
        op(OP_SUBB, 8'h00, 8'h01);
        chk(16'h800e, {flags_q & 8'hc5, acc_q});
        op(OP_RRC, 8'h00, 8'h00);
        chk(9'h087, {flags_q[7], acc_q});
        op(OP_RLC, 8'h00, 8'h00);
        chk(9'h10e, {flags_q[7], acc_q});
        op(OP_ADDC, 8'h00, 8'h01);
        chk(16'h4010, {flags_q & 8'hc5, acc_q});
        op(OP_DIR_WR, ADR_B, 8'h04);
        op(OP_DIV, 8'h00, 8'h00);
        chk(24'h000004, {flags_q & 8'h84, b_q, acc_q});
        op(OP_BITTEST, 8'h00, 8'h40);
        chk(8'h04, flags_q & 8'h04);
    endtask : t_more
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        chk(24'h070000, {sp_q, pc_q});
        chk(8'h01, flags_q);
        @(negedge clk_sys);
        t_stack();
        t_alu();
        t_bank();
        t_xdata();
        t_more();
        op_valid = 1'b0;
        give_verdict();
    end
endmodule : cpu_core_register_set_test
`default_nettype wire
